// ===== rtl/global_timer_comparator.sv
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "gtimer_defines.svh"

module global_timer_comparator
	import gtimer_pkg::*;
#(
	parameter int CNT_W = 64
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	output logic [7:0] irq_line
);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	bus_req_s req_q;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] cmp_q;
	logic [31:0] incr_q;
	control_s ctl_q;
	logic flag_q;
	logic mask_q;
	logic armed_q;
	logic match;
	logic wr_ctl;
	logic wr_st;
	logic wr_mask;
	logic wr_incr;
	logic wr_clo;
	logic wr_chi;
	logic wr_plo;
	logic wr_phi;
	logic flag_clr;
	logic irq_d;
	logic [31:0] rd_d;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input bus_req_s r, input logic [7:0] a);
		hit = r.sel && r.write && (r.addr == a);
	endfunction : hit

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			req_q <= '0;
		end else if (hready) begin
			req_q.sel <= hsel && (htrans == HTRANS_NONSEQ
				|| htrans == HTRANS_SEQ);
			req_q.write <= hwrite;
			req_q.addr <= {haddr[7:2], 2'b00};
		end else begin
			req_q <= req_q;
		end
	end

	// ----------------------------------------------------------------
	// write strobes
	// ----------------------------------------------------------------
	// one strobe per writable word, valid in the data phase
	localparam int N_WR = 8;
	localparam logic [7:0] WR_OFS [N_WR] = '{
		`OFS_COUNT_LO,
		`OFS_COUNT_HI,
		`OFS_CONTROL,
		`OFS_STATUS,
		`OFS_CMP_LO,
		`OFS_CMP_HI,
		`OFS_INCR,
		`OFS_MASK
	};
	logic [N_WR-1:0] wr_vec;

	for (genvar i = 0; i < N_WR; i++) begin : g_wr
		assign wr_vec[i] = hit(req_q, WR_OFS[i]);
	end

	assign wr_clo = wr_vec[0];
	assign wr_chi = wr_vec[1];
	assign wr_ctl = wr_vec[2];
	assign wr_st = wr_vec[3];
	assign wr_plo = wr_vec[4];
	assign wr_phi = wr_vec[5];
	assign wr_incr = wr_vec[6];
	assign wr_mask = wr_vec[7];

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// read data registered at address phase for zero-wait answer
	always_comb begin
		rd_d = 32'h0000_0000;
		case ({haddr[7:2], 2'b00})
			`OFS_COUNT_LO: rd_d = count_q[31:0];
			`OFS_COUNT_HI: rd_d = count_q[63:32];
			`OFS_CONTROL: rd_d = {28'h0000000, ctl_q};
			`OFS_STATUS: rd_d = {31'h00000000, flag_q};
			`OFS_CMP_LO: rd_d = cmp_q[31:0];
			`OFS_CMP_HI: rd_d = cmp_q[63:32];
			`OFS_INCR: rd_d = incr_q;
			`OFS_MASK: rd_d = {31'h00000000, mask_q};
			`OFS_IRQ_ID: rd_d = {24'h000000, `GT_IRQ_LINE};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && !hwrite && htrans[1]) begin
			hrdata <= rd_d;
		end else begin
			hrdata <= hrdata;
		end
	end

	// ----------------------------------------------------------------
	// bus response
	// ----------------------------------------------------------------
	// always ready, always okay
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control and increment
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctl_q <= `RST_CONTROL;
		end else if (wr_ctl) begin
			ctl_q <= hwdata[`CTL_WIDTH-1:0];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			incr_q <= `RST_INCR;
		end else if (wr_incr) begin
			incr_q <= hwdata;
		end
	end

	// ----------------------------------------------------------------
	// event mask
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mask_q <= `RST_MASK;
		end else if (wr_mask) begin
			mask_q <= hwdata[`ST_EVENT];
		end
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	localparam int N_WORD = CNT_W / 32;
	logic [N_WORD-1:0] wr_count_w;
	logic [N_WORD-1:0] wr_cmp_w;
	logic [CNT_W-1:0] count_inc;
	logic [CNT_W-1:0] cmp_inc;
	logic [31:0] count_d [N_WORD];
	logic [31:0] cmp_d [N_WORD];

	// low word first in each strobe vector
	assign wr_count_w = {wr_chi, wr_clo};
	assign wr_cmp_w = {wr_phi, wr_plo};
	// wraps silently at full width
	assign count_inc = count_q + CNT_W'(1);
	assign cmp_inc = cmp_q + CNT_W'(incr_q);

	// a word write overrides counting for the whole value that cycle
	for (genvar w = 0; w < N_WORD; w++) begin : g_word
		always_comb begin
			count_d[w] = count_q[w*32 +: 32];
			if (wr_count_w[w]) begin
				count_d[w] = hwdata;
			end else if (!(|wr_count_w) && ctl_q.count_en) begin
				count_d[w] = count_inc[w*32 +: 32];
			end
		end

		always_comb begin
			cmp_d[w] = cmp_q[w*32 +: 32];
			if (wr_cmp_w[w]) begin
				cmp_d[w] = hwdata;
			end else if (!(|wr_cmp_w) && match && ctl_q.auto_inc) begin
				cmp_d[w] = cmp_inc[w*32 +: 32];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_q <= '0;
		end else begin
			for (int w = 0; w < N_WORD; w++) begin
				count_q[w*32 +: 32] <= count_d[w];
			end
		end
	end

	// ----------------------------------------------------------------
	// comparator
	// ----------------------------------------------------------------
	// armed drops after a single-shot match and only rearms on a new
	// comparator value or compare enable edge, so a raised comparator
	// while the flag is being cleared cannot retrigger until the comparator is rewritten or compare enable rises
	assign match = ctl_q.cmp_en && armed_q && (count_q >= cmp_q);

	// comparator words, auto-increment merged in per word
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmp_q <= '0;
		end else begin
			for (int w = 0; w < N_WORD; w++) begin
				cmp_q[w*32 +: 32] <= cmp_d[w];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b1;
		end else if (wr_plo || wr_phi) begin
			armed_q <= 1'b1;
		end else if (wr_ctl && hwdata[`CTL_CMP_EN] && !ctl_q.cmp_en) begin
			armed_q <= 1'b1;
		end else if (match && !ctl_q.auto_inc) begin
			armed_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// event flag and interrupt
	// ----------------------------------------------------------------
	// set wins over a clear in the same cycle
	assign flag_clr = wr_st && hwdata[`ST_EVENT];
	assign irq_d = flag_q && mask_q && ctl_q.irq_en;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (match) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt output
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_d;
		end
	end

	// ----------------------------------------------------------------
	// distributor line
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_line <= 8'h00;
		end else begin
			irq_line <= `GT_IRQ_LINE;
		end
	end

endmodule : global_timer_comparator

// ===== inc/gtimer_defines.svh
`ifndef GTIMER_DEFINES_SVH
`define GTIMER_DEFINES_SVH

// register byte addresses
`define OFS_COUNT_LO 8'h00
`define OFS_COUNT_HI 8'h04
`define OFS_CONTROL 8'h08
`define OFS_STATUS 8'h0c
`define OFS_CMP_LO 8'h10
`define OFS_CMP_HI 8'h14
`define OFS_INCR 8'h18
`define OFS_MASK 8'h1c
`define OFS_IRQ_ID 8'h20

// control fields
`define CTL_COUNT_EN 0
`define CTL_CMP_EN 1
`define CTL_IRQ_EN 2
`define CTL_AUTO_INC 3
`define CTL_WIDTH 4

// status fields
`define ST_EVENT 0

// reset values
`define RST_CONTROL 4'h0
`define RST_MASK 1'h1
`define RST_INCR 32'h0000_0000

// distributor line of this timer
`define GT_IRQ_LINE 8'h1b

`endif

// ===== inc/gtimer_pkg.sv
package gtimer_pkg;

	typedef enum logic [1:0] {
		HTRANS_IDLE = 2'b00,
		HTRANS_BUSY = 2'b01,
		HTRANS_NONSEQ = 2'b10,
		HTRANS_SEQ = 2'b11
	} htrans_e;

	typedef struct packed {
		logic sel;
		logic write;
		logic [7:0] addr;
	} bus_req_s;

	typedef struct packed {
		logic auto_inc;
		logic irq_en;
		logic cmp_en;
		logic count_en;
	} control_s;

endpackage : gtimer_pkg

// ===== tb/gt_asserts.sv
`timescale 1ns/1ps
module gt_asserts(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq,
	input wire logic [7:0] irq_line
);
	logic t, wd_q, wc_q;
	logic [3:0] c_q;
	assign t = hsel && hready && htrans[1];
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wd_q <= 1'b0;
			wc_q <= 1'b0;
			c_q <= 4'h0;
		end else begin
			wd_q <= t && hwrite;
			wc_q <= t && hwrite && haddr[7:0] == 8'h08;
			if (wc_q)
				c_q <= hwdata[3:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_id; !$past(rst) |-> irq_line == 8'h1b; endproperty
	a_id: assert property (p_id) else $error("bad line");
	property p_rid; $past(t && !hwrite && haddr[7:0] == 8'h20)
		|-> hrdata == 32'h1b; endproperty
	a_rid: assert property (p_rid) else $error("bad id");
	property p_on; $rose(irq) |-> $past(c_q[2]); endproperty
	a_on: assert property (p_on) else $error("irq on");
	property p_off; !c_q[2] [*2] |-> !irq; endproperty
	a_off: assert property (p_off) else $error("irq off");
	property p_fall; $fell(irq) |-> $past(wd_q, 2); endproperty
	a_fall: assert property (p_fall) else $error("irq fell");
	property p_ctl; $past(t && !hwrite && haddr[7:0] == 8'h08)
		|-> hrdata[3:0] == $past(c_q); endproperty
	a_ctl: assert property (p_ctl) else $error("bad ctl");
	property p_ok; hreadyout && !hresp; endproperty
	a_ok: assert property (p_ok) else $error("bad resp");
	property p_hold; !$past(t && !hwrite) |-> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("rdata moved");
	c_rise: cover property ($rose(irq));
	c_fall: cover property ($fell(irq));
	c_rid: cover property (t && haddr[7:0] == 8'h20);
endmodule : gt_asserts
bind global_timer_comparator gt_asserts chk_u(.*);

// ===== tb/irq_dist_model.sv
`timescale 1ns/1ps
module irq_dist_model(
	input wire logic clock,
	input wire logic rst,
	input wire logic irq,
	input wire logic [7:0] irq_line,
	output logic [7:0] reqs_q
);
	logic irq_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
			reqs_q <= 8'h00;
		end else begin
			irq_q <= irq;
			if (irq && !irq_q && irq_line == 8'h1b)
				reqs_q <= reqs_q + 8'h01;
		end
	end
endmodule : irq_dist_model

// ===== tb/tb_global_timer_comparator.sv
`timescale 1ns/1ps
module tb_global_timer_comparator;
	logic clock = 0, rst = 1, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r, s;
	logic hreadyout, hresp, irq;
	logic [7:0] irq_line, reqs_q;
	int miscompares = 0, n_compared = 0, cyc = 0;
	logic [31:0] rows [7][3] = '{'{32'h08, 32'h08, 32'h08},
		'{32'h18, 32'h05, 32'h05}, '{32'h10, 32'h40, 32'h40},
		'{32'h1c, 32'h00, 32'h00}, '{32'h20, 32'h00, 32'h1b},
		'{32'h24, 32'hff, 32'h00}, '{32'h1c, 32'h01, 32'h01}};
	global_timer_comparator dut_u(.clock, .rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .irq, .irq_line);
	irq_dist_model ic_u(.clock, .rst, .irq, .irq_line, .reqs_q);
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc > 5000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: %h not %h", $time, g, e);
		end
	endtask : chk
	task automatic wirq();
		repeat (3) @(posedge clock);
		#1;
		repeat (300) if (irq !== 1'b1) #10;
		repeat (2) @(posedge clock);
	endtask : wirq
	task automatic final_report();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		foreach (rows[i]) begin
			bus(1, rows[i][0], rows[i][1]);
			bus(0, rows[i][0], 32'h0);
			chk(r, rows[i][2]);
		end
		$display("rows done");
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		bus(0, 32'h08, 32'h0);
		chk(r, 32'h0);
		bus(0, 32'h1c, 32'h0);
		chk(r, 32'h1);
		chk(irq_line, 32'h1b);
		$display("reset done");
		bus(1, 32'h10, 32'h40);
		bus(1, 32'h08, 32'h7);
		wirq();
		chk(irq, 32'h1);
		bus(1, 32'h10, 32'hffff);
		bus(1, 32'h0c, 32'h1);
		repeat (60) @(posedge clock);
		chk(irq, 32'h0);
		bus(1, 32'h08, 32'h5);
		bus(1, 32'h10, 32'h0);
		repeat (20) @(posedge clock);
		chk(irq, 32'h0);
		bus(1, 32'h08, 32'h7);
		wirq();
		chk(reqs_q, 32'h2);
		bus(1, 32'h0c, 32'h1);
		$display("compare done");
		bus(1, 32'h08, 32'h0);
		bus(0, 32'h00, 32'h0);
		s = r;
		bus(0, 32'h00, 32'h0);
		chk(r, s);
		bus(1, 32'h08, 32'h1);
		bus(0, 32'h00, 32'h0);
		chk(r != s, 32'h1);
		bus(1, 32'h18, 32'h1e);
		bus(1, 32'h00, 32'h0);
		bus(1, 32'h10, 32'h40);
		bus(1, 32'h08, 32'hf);
		wirq();
		bus(1, 32'h0c, 32'h1);
		wirq();
		chk(reqs_q, 32'h4);
		$display("auto done");
		final_report();
	end
endmodule : tb_global_timer_comparator
